// ==== rtl/csch_top.sv ====
`timescale 1ns/1ps
`include "csch_cfg.svh"
module csch_top
    import csch_pkg::*;
#(
    parameter int N_TASKS = 4,
    parameter int PIXELS = 8192,
    parameter logic [31:0] LINE_MAX_HZ = 32'h0000_9c40,
    parameter logic [31:0] LINE_STEP_HZ = 32'h0000_0064
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pixel stream
    input wire logic pix_valid,
    input wire logic [13:0] pix_index,
    input wire logic [1:0] pix_tap,
    input wire logic [9:0] pix_data,
    output logic vid_valid,
    output logic [9:0] vid_data,
    // Settings to the pipeline
    output logic data_10bit,
    output logic [9:0] lower_thr,
    output logic [9:0] upper_thr,
    output logic [3:0] pretrigger,
    output logic [31:0] line_rate_hz,
    output logic [1:0] video_mode,
    output wire [35:0] bkg_sub,
    output wire [35:0] dig_gain,
    output wire [31:0] ana_gain,
    // Monitors and messages
    input wire logic supply_good,
    input wire logic [N_TASKS-1:0] warn_event,
    output logic net_msg_valid,
    output logic [N_TASKS-1:0] net_msg_task,
    // Nonvolatile memory write port
    output logic nvm_wr,
    output logic [15:0] nvm_addr,
    output logic [31:0] nvm_wdata,
    // Interrupt
    output logic irq
);
    localparam int AW = $clog2(PIXELS);
    localparam logic [AW:0] PIX_LAST = (AW+1)'(PIXELS - 1);

    csch_state_e state_q;
    logic [AW:0] cnt_q;
    logic pend_q, pend_last_q;
    logic [AW-1:0] pend_addr_q;
    logic [1:0] data_mode_q;
    logic netmsg_q;
    logic [2:0] expo_q;
    logic [N_TASKS-1:0] warn_en_q;
    logic last_err_q, volt_valid_q, volt_ok_q;
    logic sg_s1_q, sg_s2_q;
    logic [N_TASKS-1:0] wev_s1_q, wev_s2_q, wev_s3_q;
    logic [3:0] irq_st_q, irq_en_q;
    logic p1_valid_q;
    logic [9:0] p1_data_q;
    logic [1:0] p1_tap_q, p1_mode_q;
    logic p1_steal_q;
    logic [13:0] p1_idx_q;
    logic [8:0] coef_rdata;

    // Address decode
    wire hit_dm = reg_addr == `CSCH_A_DATA_MODE;
    wire hit_lt = reg_addr == `CSCH_A_LOWER_THR;
    wire hit_ut = reg_addr == `CSCH_A_UPPER_THR;
    wire hit_nm = reg_addr == `CSCH_A_NETMSG;
    wire hit_pt = reg_addr == `CSCH_A_PRETRIG;
    wire hit_pc = reg_addr == `CSCH_A_PRNU;
    wire hit_bk = reg_addr == `CSCH_A_BKG;
    wire hit_lr = reg_addr == `CSCH_A_LINE_RATE;
    wire hit_ex = reg_addr == `CSCH_A_EXPO;
    wire hit_dg = reg_addr == `CSCH_A_DGAIN;
    wire hit_vm = reg_addr == `CSCH_A_VIDEO;
    wire hit_ag = reg_addr == `CSCH_A_AGAIN;
    wire hit_vv = reg_addr == `CSCH_A_VOLT;
    wire hit_wd = reg_addr == `CSCH_A_WARN;
    wire hit_wc = reg_addr == `CSCH_A_SAVE_COEF;
    wire hit_wu = reg_addr == `CSCH_A_SAVE_USER;
    wire hit_ic = reg_addr == `CSCH_A_IRQ_CLR;
    wire hit_ie = reg_addr == `CSCH_A_IRQ_EN;
    wire cmd_hit = hit_dm | hit_lt | hit_ut | hit_nm | hit_pt | hit_pc | hit_bk | hit_lr | hit_ex
        | hit_dg | hit_vm | hit_ag | hit_vv | hit_wd | hit_wc | hit_wu;

    // Parameter fields
    wire [2:0] f_tap = reg_wdata[`CSCH_TAP_LSB +: 3];
    wire [8:0] f_val9 = reg_wdata[8:0];
    wire [13:0] f_pix = reg_wdata[13:0];
    wire [8:0] f_coef = reg_wdata[`CSCH_COEF_LSB +: 9];
    wire signed [4:0] f_again = reg_wdata[4:0];
    wire [3:0] f_task = reg_wdata[3:0];
    wire [9:0] thr_max = data_10bit ? `CSCH_THR10_MAX : `CSCH_THR8_MAX; // see RULE1 see RULE2
    wire [31:0] rate_rnd = 32'(((reg_wdata + (LINE_STEP_HZ >> 1)) / LINE_STEP_HZ) * LINE_STEP_HZ); // see RULE7
    wire busy = state_q != CSCH_IDLE || pend_q;

    // Range checks per command
    wire thr_ok = reg_wdata[31:10] == 22'h0 && reg_wdata[9:0] <= thr_max; // see RULE1 see RULE2
    wire tap_ok = f_tap <= 3'h4 && reg_wdata[31:19] == 13'h0;
    wire tv_ok = tap_ok && reg_wdata[15:9] == 7'h0; // see RULE6 see RULE8
    wire pc_ok = f_pix >= 14'h1 && f_pix <= 14'(PIXELS) && reg_wdata[15:14] == 2'h0
        && reg_wdata[31:25] == 7'h0; // see RULE5
    wire ag_ok = tap_ok && reg_wdata[15:5] == 11'h0 && f_again >= $signed(`CSCH_AGAIN_MIN)
        && f_again <= $signed(`CSCH_AGAIN_MAX);
    wire lr_ok = expo_q == `CSCH_EXPO_PROG && reg_wdata >= `CSCH_LINE_MIN_HZ && reg_wdata <= LINE_MAX_HZ;
    wire ex_ok = reg_wdata >= 32'h1 && reg_wdata <= 32'(`CSCH_EXPO_MAX);
    wire wd_ok = 32'(f_task) < 32'(N_TASKS) && reg_wdata[31:9] == 23'h0 && reg_wdata[7:4] == 4'h0;
    wire param_ok = (hit_lt || hit_ut) ? thr_ok :
        hit_dm ? reg_wdata[31:2] == 30'h0 : // see RULE15
        hit_nm ? reg_wdata[31:1] == 31'h0 : // see RULE3
        hit_pt ? reg_wdata <= `CSCH_PRETRIG_MAX : // see RULE4
        hit_pc ? pc_ok :
        (hit_bk || hit_dg) ? tv_ok :
        hit_lr ? lr_ok :
        hit_ex ? ex_ok :
        hit_vm ? reg_wdata <= 32'h2 : // see RULE9
        hit_ag ? ag_ok :
        hit_wd ? wd_ok : 1'b1;
    wire acc = reg_wr && cmd_hit && param_ok && !busy;
    wire cmd_err_ev = reg_wr && (cmd_hit ? (!param_ok || busy) : !(hit_ic || hit_ie)); // see RULE16

    // Plain settings
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            data_mode_q <= `CSCH_DATA_MODE_RST;
            lower_thr <= `CSCH_THR_RST;
            upper_thr <= `CSCH_THR_RST;
            netmsg_q <= `CSCH_NETMSG_RST;
            pretrigger <= `CSCH_PRETRIG_RST;
            expo_q <= `CSCH_EXPO_RST;
            video_mode <= `CSCH_VIDEO_RST;
            line_rate_hz <= LINE_MAX_HZ;
        end else if (acc) begin
            if (hit_dm) data_mode_q <= reg_wdata[1:0];
            if (hit_lt) lower_thr <= reg_wdata[9:0]; // see RULE1
            if (hit_ut) upper_thr <= reg_wdata[9:0]; // see RULE2
            if (hit_nm) netmsg_q <= reg_wdata[0]; // see RULE3
            if (hit_pt) pretrigger <= reg_wdata[3:0]; // see RULE4
            if (hit_ex) expo_q <= reg_wdata[2:0];
            if (hit_vm) video_mode <= reg_wdata[1:0]; // see RULE9
            if (hit_lr) line_rate_hz <= rate_rnd; // see RULE7
        end
    end
    assign data_10bit = data_mode_q[0]; // see RULE15

    // Per-tap settings: tap 0 selects all taps
    genvar t;
    generate
        for (t = 0; t < 4; t++) begin : g_tap
            logic [8:0] bkg_q, dg_q;
            logic [7:0] ag_q;
            wire sel = f_tap == 3'h0 || f_tap == 3'(t + 1);
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    bkg_q <= `CSCH_TAPVAL_RST;
                    dg_q <= `CSCH_TAPVAL_RST;
                    ag_q <= `CSCH_AGAIN_NOM;
                end else if (acc && sel) begin
                    if (hit_bk) bkg_q <= f_val9; // see RULE6
                    if (hit_dg) dg_q <= f_val9; // see RULE8
                    if (hit_ag) ag_q <= `CSCH_AGAIN_NOM + {{3{f_again[4]}}, f_again}; // see RULE10
                end
            end
            assign bkg_sub[t*9 +: 9] = bkg_q;
            assign dig_gain[t*9 +: 9] = dg_q;
            assign ana_gain[t*8 +: 8] = ag_q;
        end
    endgenerate

    // Coefficient memory ports: clear sweep, command writes, save and pixel reads
    wire clearing = state_q == CSCH_CLEAR;
    wire coef_we = clearing || (acc && hit_pc);
    wire [AW-1:0] coef_waddr = clearing ? cnt_q[AW-1:0] : AW'(f_pix - 14'h1);
    wire [8:0] coef_wdata = clearing ? 9'h000 : f_coef;
    wire steal = state_q == CSCH_SAVE_COEF;
    wire [AW-1:0] coef_raddr = steal ? cnt_q[AW-1:0] : pix_index[AW-1:0];

    csch_coef_mem #(.DEPTH(PIXELS), .WIDTH(9), .AW(AW)) u_mem (
        .clk(sys_clk),
        .we(coef_we),
        .waddr(coef_waddr),
        .wdata(coef_wdata),
        .raddr(coef_raddr),
        .rdata(coef_rdata)
    );

    // Save sequencer
    wire seq_last = cnt_q == (state_q == CSCH_SAVE_USER ? (AW+1)'(`CSCH_USER_WORDS - 3'h1) : PIX_LAST);
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= CSCH_CLEAR;
            cnt_q <= '0;
        end else begin
            case (state_q)
                CSCH_IDLE: begin
                    cnt_q <= '0;
                    if (acc && hit_wc) state_q <= CSCH_SAVE_COEF; // see RULE13
                    if (acc && hit_wu) state_q <= CSCH_SAVE_USER; // see RULE14
                end
                CSCH_CLEAR, CSCH_SAVE_COEF, CSCH_SAVE_USER: begin
                    cnt_q <= seq_last ? '0 : cnt_q + 1'b1;
                    if (seq_last) state_q <= CSCH_IDLE;
                end
                default: state_q <= CSCH_IDLE;
            endcase
        end
    end

    // User settings image, coefficients excluded
    wire [2:0] uw = cnt_q[2:0];
    wire [31:0] user_word = uw == 3'h0 ? 32'({warn_en_q, video_mode, expo_q, pretrigger, netmsg_q, data_mode_q}) :
        uw == 3'h1 ? {12'h0, upper_thr, lower_thr} :
        uw == 3'h2 ? line_rate_hz :
        32'({ana_gain[(uw-3'h3)*8 +: 8], dig_gain[(uw-3'h3)*9 +: 9], bkg_sub[(uw-3'h3)*9 +: 9]});
    wire save_done_ev = pend_last_q || (state_q == CSCH_SAVE_USER && seq_last);

    // Nonvolatile write stream
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pend_q <= 1'b0;
            pend_last_q <= 1'b0;
            pend_addr_q <= '0;
            nvm_wr <= 1'b0;
            nvm_addr <= 16'h0;
            nvm_wdata <= 32'h0;
        end else begin
            pend_q <= steal; // see RULE13
            pend_last_q <= steal && seq_last;
            pend_addr_q <= cnt_q[AW-1:0];
            nvm_wr <= pend_q || state_q == CSCH_SAVE_USER;
            nvm_addr <= pend_q ? `CSCH_NVM_COEF_BASE + 16'(pend_addr_q) : `CSCH_NVM_USER_BASE + 16'(cnt_q); // see RULE14
            nvm_wdata <= pend_q ? 32'(coef_rdata) : user_word;
        end
    end

    // Pixel pipeline: stage one fetches the coefficient
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            p1_valid_q <= 1'b0;
            p1_data_q <= 10'h0;
            p1_tap_q <= 2'h0;
            p1_mode_q <= 2'h0;
            p1_steal_q <= 1'b0;
            p1_idx_q <= 14'h0;
        end else begin
            p1_valid_q <= pix_valid;
            p1_data_q <= pix_data;
            p1_tap_q <= pix_tap;
            p1_mode_q <= video_mode;
            p1_steal_q <= steal;
            p1_idx_q <= pix_index;
        end
    end

    // Correction: background subtraction then gain of 1 + coef/512
    wire [8:0] bkg_sel = bkg_sub[9*p1_tap_q +: 9];
    wire [10:0] diff = {1'b0, p1_data_q} - {2'b0, bkg_sel}; // see RULE6
    wire [9:0] net = diff[10] ? 10'h0 : diff[9:0];
    wire [9:0] coef_use = p1_steal_q ? 10'h0 : {1'b0, coef_rdata};
    wire [19:0] prod = net * (`CSCH_COEF_UNITY + coef_use); // see RULE5
    wire [10:0] scaled = prod[19:9];
    wire [9:0] cal_out = scaled[10] ? 10'h3ff : scaled[9:0];
    wire [9:0] vid_sel = p1_mode_q == CSCH_VID_CAL ? cal_out :
        p1_mode_q == CSCH_VID_TEST ? p1_idx_q[9:0] : p1_data_q; // see RULE9

    // Video output stage
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            vid_valid <= 1'b0;
            vid_data <= 10'h0;
        end else begin
            vid_valid <= p1_valid_q;
            vid_data <= vid_sel;
        end
    end

    // Monitor inputs through two flops
    wire [N_TASKS-1:0] warn_edge = wev_s2_q & ~wev_s3_q & warn_en_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sg_s1_q <= 1'b0;
            sg_s2_q <= 1'b0;
            wev_s1_q <= '0;
            wev_s2_q <= '0;
            wev_s3_q <= '0;
        end else begin
            sg_s1_q <= supply_good;
            sg_s2_q <= sg_s1_q;
            wev_s1_q <= warn_event;
            wev_s2_q <= wev_s1_q;
            wev_s3_q <= wev_s2_q;
        end
    end

    // Checks, warnings and unsolicited messages
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            warn_en_q <= '1;
            volt_valid_q <= 1'b0;
            volt_ok_q <= 1'b0;
            last_err_q <= 1'b0;
            net_msg_valid <= 1'b0;
            net_msg_task <= '0;
        end else begin
            if (acc && hit_wd) warn_en_q[f_task[$clog2(N_TASKS)-1:0]] <= reg_wdata[`CSCH_WARN_EN_BIT]; // see RULE12
            if (acc && hit_vv) begin
                volt_valid_q <= 1'b1; // see RULE11
                volt_ok_q <= sg_s2_q;
            end
            last_err_q <= cmd_err_ev || (last_err_q && !acc); // see RULE16
            net_msg_valid <= |warn_edge && !netmsg_q; // see RULE3
            net_msg_task <= netmsg_q ? '0 : warn_edge;
        end
    end

    // Interrupt status: set wins over clear
    wire [3:0] irq_ev = {|warn_edge, save_done_ev, acc && hit_vv, cmd_err_ev};
    wire [3:0] irq_clr = (reg_wr && hit_ic) ? reg_wdata[3:0] : 4'h0;
    wire [3:0] irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_st_q <= 4'h0;
            irq_en_q <= 4'h0;
            irq <= 1'b0;
        end else begin
            irq_st_q <= irq_st_d;
            if (reg_wr && hit_ie) irq_en_q <= reg_wdata[3:0];
            irq <= |(irq_st_d & irq_en_q);
        end
    end

    // Read data mux, valid only the cycle after the strobe
    wire [31:0] rd_mux = hit_dm ? 32'(data_mode_q) :
        hit_lt ? 32'(lower_thr) :
        hit_ut ? 32'(upper_thr) :
        hit_nm ? 32'(netmsg_q) :
        hit_pt ? 32'(pretrigger) :
        hit_lr ? line_rate_hz :
        hit_ex ? 32'(expo_q) :
        hit_vm ? 32'(video_mode) :
        hit_wd ? 32'(warn_en_q) : // see RULE12
        reg_addr == `CSCH_A_STATUS ? {28'h0, volt_ok_q, volt_valid_q, busy, last_err_q} :
        reg_addr == `CSCH_A_IRQ_STAT ? {28'h0, irq_st_q} :
        hit_ie ? {28'h0, irq_en_q} : 32'h0;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // Checks on the command behaviour
    a_lower_thr_reject: assert property (@(posedge sys_clk) disable iff (reset) // see RULE1
        (reg_wr && hit_lt && reg_wdata > 32'(thr_max)) |=> $stable(lower_thr))
        else $error("lower threshold took an out of range value");
    a_upper_thr_take: assert property (@(posedge sys_clk) disable iff (reset) // see RULE2
        (acc && hit_ut) |=> upper_thr == $past(reg_wdata[9:0]) && upper_thr <= `CSCH_THR10_MAX)
        else $error("upper threshold not stored");
    a_netmsg_quiet: assert property (@(posedge sys_clk) disable iff (reset) // see RULE3
        $past(netmsg_q) |-> !net_msg_valid)
        else $error("message sent while suppressed");
    a_pretrig_range: assert property (@(posedge sys_clk) disable iff (reset) // see RULE4
        (reg_wr && hit_pt && reg_wdata > `CSCH_PRETRIG_MAX) |=> $stable(pretrigger) && last_err_q)
        else $error("pretrigger range not enforced");
    a_prnu_unity: assert property (@(posedge sys_clk) disable iff (reset) // see RULE5
        (p1_mode_q == CSCH_VID_CAL && coef_use == 10'h0 && bkg_sel == 9'h0) |=> vid_data == $past(p1_data_q))
        else $error("zero coefficient changed the pixel");
    a_bkg_subtract: assert property (@(posedge sys_clk) disable iff (reset) // see RULE6
        (p1_mode_q == CSCH_VID_CAL && coef_use == 10'h0 && p1_data_q >= 10'(bkg_sel))
        |=> vid_data == $past(p1_data_q - 10'(bkg_sel)))
        else $error("background not subtracted");
    a_line_mode: assert property (@(posedge sys_clk) disable iff (reset) // see RULE7
        (reg_wr && hit_lr && expo_q != `CSCH_EXPO_PROG) |=> $stable(line_rate_hz))
        else $error("line rate changed outside exposure mode 2");
    a_dgain_range: assert property (@(posedge sys_clk) disable iff (reset) // see RULE8
        (reg_wr && hit_dg && !tv_ok) |=> $stable(dig_gain))
        else $error("digital gain took an invalid value");
    a_video_test: assert property (@(posedge sys_clk) disable iff (reset) // see RULE9
        (p1_mode_q == CSCH_VID_TEST) |=> vid_data == $past(p1_idx_q[9:0]))
        else $error("test pattern not selected");
    a_again_nominal: assert property (@(posedge sys_clk) disable iff (reset) // see RULE10
        (acc && hit_ag && f_again == 5'sh0 && f_tap == 3'h0) |=> ana_gain == {4{`CSCH_AGAIN_NOM}})
        else $error("zero gain is not nominal");
    a_volt_reply: assert property (@(posedge sys_clk) disable iff (reset) // see RULE11
        (acc && hit_vv) |=> volt_valid_q && volt_ok_q == $past(sg_s2_q) && irq_st_q[1])
        else $error("voltage check reply wrong");
    a_coef_stream: assert property (@(posedge sys_clk) disable iff (reset) // see RULE13
        pend_q |=> nvm_wr && nvm_addr >= `CSCH_NVM_COEF_BASE)
        else $error("coefficient save lost a word");
    a_user_stream: assert property (@(posedge sys_clk) disable iff (reset) // see RULE14
        (state_q == CSCH_SAVE_USER) |=> nvm_wr && nvm_addr < `CSCH_NVM_COEF_BASE)
        else $error("user save wrote outside its area");
    a_err_flag: assert property (@(posedge sys_clk) disable iff (reset) // see RULE16
        cmd_err_ev |=> irq_st_q[0] && last_err_q)
        else $error("rejected command not reported");
endmodule

// ==== inc/csch_cfg.svh ====
// Contract
// RULE1: Lower threshold accepts 0..255 in 8-bit data modes, 0..1023 in 10-bit modes.
// RULE2: Upper threshold accepts 0..255 in 8-bit data modes, 0..1023 in 10-bit modes.
// RULE3: Net message value 0 (default) allows unsolicited messages, 1 suppresses them.
// RULE4: Pretrigger takes an integer from 0 to 15.
// RULE5: Pixel coefficient: pixel 1..8192, value 0..511, gain is 1 + value/512. The code uses gain 1 while a coefficient save runs.
// RULE6: Background subtraction: tap 1..4 or 0 for all, subtract 0..511 from output.
// RULE7: Line rate settable in exposure mode 2 from 1000 Hz to maximum, rounded.
// RULE8: Digital gain: tap 1..4 or 0 for all, gain value 0..511.
// RULE9: Video mode 0 uncorrected, 1 corrected, 2 test pattern.
// RULE10: Analog gain value zero means the nominal gain.
// RULE11: Voltage check samples supply state and answers OK or fail.
// RULE12: Warning control reads all task enables, or enables/disables one task.
// RULE13: Coefficient save copies every pixel coefficient to nonvolatile memory.
// RULE14: User settings save stores all settings except pixel coefficients.
// RULE15: Data modes 0 and 2 are 8-bit, 1 and 3 are 10-bit.
// RULE16: Out-of-range parameter is rejected, setting kept, error reported.
`ifndef CSCH_CFG_SVH
`define CSCH_CFG_SVH
// Command and register offsets
`define CSCH_A_DATA_MODE 8'h00
`define CSCH_A_LOWER_THR 8'h04
`define CSCH_A_UPPER_THR 8'h08
`define CSCH_A_NETMSG 8'h0c
`define CSCH_A_PRETRIG 8'h10
`define CSCH_A_PRNU 8'h14
`define CSCH_A_BKG 8'h18
`define CSCH_A_LINE_RATE 8'h1c
`define CSCH_A_EXPO 8'h20
`define CSCH_A_DGAIN 8'h24
`define CSCH_A_VIDEO 8'h28
`define CSCH_A_AGAIN 8'h2c
`define CSCH_A_VOLT 8'h30
`define CSCH_A_WARN 8'h34
`define CSCH_A_SAVE_COEF 8'h38
`define CSCH_A_SAVE_USER 8'h3c
`define CSCH_A_STATUS 8'h40
`define CSCH_A_IRQ_STAT 8'h44
`define CSCH_A_IRQ_CLR 8'h48
`define CSCH_A_IRQ_EN 8'h4c
// Field positions
`define CSCH_TAP_LSB 16
`define CSCH_COEF_LSB 16
`define CSCH_WARN_EN_BIT 8
// Limits
`define CSCH_THR8_MAX 10'h0ff
`define CSCH_THR10_MAX 10'h3ff
`define CSCH_PRETRIG_MAX 32'h0000_000f
`define CSCH_COEF_UNITY 10'h200
`define CSCH_LINE_MIN_HZ 32'h0000_03e8
`define CSCH_EXPO_PROG 3'h2
`define CSCH_EXPO_MAX 3'h6
`define CSCH_AGAIN_MIN 5'h16
`define CSCH_AGAIN_MAX 5'h0a
`define CSCH_AGAIN_NOM 8'h80
// Reset values
`define CSCH_DATA_MODE_RST 2'h0
`define CSCH_THR_RST 10'h000
`define CSCH_NETMSG_RST 1'h0
`define CSCH_PRETRIG_RST 4'h0
`define CSCH_EXPO_RST 3'h1
`define CSCH_VIDEO_RST 2'h0
`define CSCH_TAPVAL_RST 9'h000
// Nonvolatile memory layout
`define CSCH_NVM_USER_BASE 16'h0000
`define CSCH_NVM_COEF_BASE 16'h2000
`define CSCH_USER_WORDS 3'h7
`endif

// ==== inc/csch_pkg.sv ====
package csch_pkg;
    // Save sequencer states
    typedef enum logic [3:0] {
        CSCH_CLEAR = 4'b0001,
        CSCH_IDLE = 4'b0010,
        CSCH_SAVE_COEF = 4'b0100,
        CSCH_SAVE_USER = 4'b1000
    } csch_state_e;
    // Video path selection
    typedef enum logic [1:0] {
        CSCH_VID_RAW = 2'h0,
        CSCH_VID_CAL = 2'h1,
        CSCH_VID_TEST = 2'h2
    } csch_vmode_e;
endpackage

// ==== rtl/csch_coef_mem.sv ====
`timescale 1ns/1ps
module csch_coef_mem #(
    parameter int DEPTH = 8192,
    parameter int WIDTH = 9,
    parameter int AW = 13
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Synchronous write, registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
        rdata <= mem_q[raddr];
    end
endmodule

// ==== sim/csch_pin_model.sv ====
`timescale 1ns/1ps
module csch_pin_model (
    // Clock and requests
    input wire logic clk,
    input wire logic good_req,
    input wire logic [3:0] event_req,
    // Monitor pins
    output logic supply_good,
    output logic [3:0] warn_event
);
    // Pins follow requests a clock late
    always @(posedge clk) begin
        supply_good <= good_req;
        warn_event <= event_req;
    end
endmodule

// ==== sim/csch_top_test.sv ====
`timescale 1ns/1ps
`include "csch_cfg.svh"
module csch_top_test;
    import csch_pkg::*;
    localparam int PIX = 16;
    logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pix_valid = 1'b0, good_req = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, line_rate_hz, nvm_wdata, rd_q, last_dat;
    logic [13:0] pix_index = 14'h0;
    logic [1:0] pix_tap = 2'h0, video_mode;
    logic [9:0] pix_data = 10'h0, vid_data, lower_thr, upper_thr;
    logic vid_valid, data_10bit, net_msg_valid, nvm_wr, irq, supply_good;
    logic [3:0] pretrigger, net_msg_task, warn_event, last_task, ev_req = 4'h0;
    wire [35:0] bkg_sub, dig_gain;
    wire [31:0] ana_gain;
    logic [15:0] nvm_addr, last_nvm;
    int err_total = 0, total_checks = 0, cyc = 0, n_wr = 0, n_msg = 0;
    csch_top #(.PIXELS(PIX)) i_csch_top (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pix_valid, .pix_index, .pix_tap, .pix_data, .vid_valid, .vid_data, .data_10bit,
        .lower_thr, .upper_thr, .pretrigger, .line_rate_hz, .video_mode, .bkg_sub, .dig_gain, .ana_gain,
        .supply_good, .warn_event, .net_msg_valid, .net_msg_task, .nvm_wr, .nvm_addr, .nvm_wdata, .irq);
    csch_pin_model i_csch_pin_model (.clk(sys_clk), .good_req, .event_req(ev_req), .supply_good,
        .warn_event);
    // Clock
    initial forever #5 sys_clk = ~sys_clk;
    task close_out();
        $display("Checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Counts stream words, messages and cycles against a hang
    always @(posedge sys_clk) begin
        cyc++;
        if (nvm_wr === 1'b1) begin
            n_wr++;
            last_nvm <= nvm_addr;
            last_dat <= nvm_wdata;
        end
        if (net_msg_valid === 1'b1) begin
            n_msg++;
            last_task <= net_msg_task;
        end
        if (cyc == 6000) begin
            err_total++;
            close_out();
        end
    end
    task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_q = reg_rdata;
    endtask
    // Command, then the error flag it should leave
    task cmd(input logic [7:0] a, input logic [31:0] d, input logic e);
        wr(a, d);
        rd(`CSCH_A_STATUS);
        chk("last_err", 36'(e), 36'(rd_q[0]));
    endtask
    task pulse(input logic [3:0] m);
        @(posedge sys_clk);
        ev_req <= m;
        repeat (8) @(posedge sys_clk);
        ev_req <= 4'h0;
        repeat (8) @(posedge sys_clk);
    endtask
    // One pixel, two cycles of valid, output looked at after the second edge
    task pix(input logic [13:0] i, input logic [9:0] d);
        @(posedge sys_clk);
        pix_valid <= 1'b1;
        pix_index <= i;
        pix_data <= d;
        repeat (2) @(posedge sys_clk);
        pix_valid <= 1'b0;
        #1;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk("ana_gain", 36'h0_8080_8080, 36'(ana_gain));
        repeat (PIX + 4) @(posedge sys_clk);
        cmd(`CSCH_A_LOWER_THR, 32'hff, 1'b0);
        cmd(`CSCH_A_LOWER_THR, 32'h100, 1'b1);
        chk("lower", 36'hff, 36'(lower_thr));
        cmd(`CSCH_A_UPPER_THR, 32'h3ff, 1'b1);
        cmd(`CSCH_A_DATA_MODE, 32'h3, 1'b0);
        chk("mode10", 36'h1, 36'(data_10bit));
        cmd(`CSCH_A_UPPER_THR, 32'h3ff, 1'b0);
        cmd(`CSCH_A_UPPER_THR, 32'h400, 1'b1);
        cmd(`CSCH_A_PRETRIG, 32'hf, 1'b0);
        cmd(`CSCH_A_PRETRIG, 32'h10, 1'b1);
        chk("pretrig", 36'hf, 36'(pretrigger));
        for (int m = 0; m < 3; m++) begin
            cmd(`CSCH_A_VIDEO, 32'(m), 1'b0);
            chk("video", 36'(m), 36'(video_mode));
        end
        cmd(`CSCH_A_VIDEO, 32'h3, 1'b1);
        pix(14'h2155, 10'h0);
        chk("pattern", 36'h555, 36'({vid_valid, vid_data}));
        cmd(`CSCH_A_BKG, 32'h0000_01ff, 1'b0);
        cmd(`CSCH_A_BKG, 32'h0005_0001, 1'b1);
        chk("bkg", {4{9'h1ff}}, bkg_sub);
        cmd(`CSCH_A_DGAIN, 32'h0002_0005, 1'b0);
        chk("dgain", 36'ha00, dig_gain);
        cmd(`CSCH_A_AGAIN, 32'h0001_0005, 1'b0);
        cmd(`CSCH_A_AGAIN, 32'h0, 1'b0);
        chk("again", 36'h0_8080_8080, 36'(ana_gain));
        cmd(`CSCH_A_LINE_RATE, 32'd1049, 1'b1);
        cmd(`CSCH_A_EXPO, 32'h2, 1'b0);
        cmd(`CSCH_A_LINE_RATE, 32'd999, 1'b1);
        cmd(`CSCH_A_LINE_RATE, 32'd1049, 1'b0);
        chk("rate", 36'd1000, 36'(line_rate_hz));
        cmd(`CSCH_A_PRNU, 32'h01ff_0010, 1'b0);
        cmd(`CSCH_A_PRNU, 32'h0000_0011, 1'b1);
        cmd(`CSCH_A_PRNU, 32'h0200_0001, 1'b1);
        cmd(`CSCH_A_VIDEO, 32'h1, 1'b0);
        pix(14'hf, 10'h2ff);
        chk("cal", 36'h5ff, 36'({vid_valid, vid_data}));
        cmd(`CSCH_A_VOLT, 32'h0, 1'b0);
        chk("volt_ok", 36'h3, 36'(rd_q[3:2]));
        good_req <= 1'b0;
        repeat (6) @(posedge sys_clk);
        cmd(`CSCH_A_VOLT, 32'h0, 1'b0);
        chk("volt_bad", 36'h1, 36'(rd_q[3:2]));
        cmd(`CSCH_A_WARN, 32'h1, 1'b0);
        rd(`CSCH_A_WARN);
        chk("warn_en", 36'hd, 36'(rd_q));
        cmd(`CSCH_A_WARN, 32'h104, 1'b1);
        cmd(`CSCH_A_NETMSG, 32'h2, 1'b1);
        n_msg = 0;
        pulse(4'h1);
        pulse(4'h2);
        cmd(`CSCH_A_NETMSG, 32'h1, 1'b0);
        pulse(4'h1);
        chk("msgs", 36'h11, 36'({n_msg[3:0], last_task}));
        wr(`CSCH_A_IRQ_CLR, 32'hf);
        cmd(`CSCH_A_IRQ_EN, 32'h1, 1'b0);
        chk("irq_idle", 36'h0, 36'(irq));
        cmd(8'h50, 32'h0, 1'b1);
        chk("irq", 36'h1, 36'(irq));
        rd(8'h50);
        chk("unmapped", 36'h0, 36'(rd_q));
        wr(`CSCH_A_IRQ_CLR, 32'hf);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("irq_clr", 36'h0, 36'(irq));
        n_wr = 0;
        cmd(`CSCH_A_SAVE_USER, 32'h0, 1'b0);
        repeat (12) @(posedge sys_clk);
        chk("user_n", 36'h7_0006, 36'({n_wr[3:0], last_nvm}));
        chk("user_dat", 36'h0_0200_01ff, 36'(last_dat));
        n_wr = 0;
        cmd(`CSCH_A_SAVE_COEF, 32'h0, 1'b0);
        repeat (PIX + 8) @(posedge sys_clk);
        chk("coef_n", 36'(PIX * 65536 + 16'h2000 + PIX - 1), 36'({n_wr[15:0], last_nvm}));
        chk("coef_dat", 36'h1ff, 36'(last_dat));
        close_out();
    end
endmodule
